// file: hw/sram_port_ctl.sv
// memory controller end: divides mclk into the link clock and drives K, C and commands
// assumes user commands are synchronous to mclk; one command slot per K cycle
`timescale 1ns/1ps
module sram_port_ctl
    import sram_link_pkg::*;
    #(parameter int ADDR_W = ADDR_W_DEF) (
    input wire logic mclk, // system clock
    input wire logic rst_n, // async reset, active low
    input wire logic use_out_clk, // 1: drive c pair, 0: tie it high
    input wire logic cmd_valid, // command offered
    output logic cmd_ready, // command slot open this cycle
    input wire logic rd_en, // command holds a read
    input wire logic [ADDR_W-1:0] rd_addr, // read burst address
    input wire logic wr_en, // command holds a write
    input wire logic [ADDR_W-1:0] wr_addr, // write burst address
    input wire logic [2*DATA_W-1:0] wr_data, // beat 1 high, beat 0 low
    input wire logic [2*LANES-1:0] wr_mask_n, // lane masks, beat 0 low
    output logic rd_valid, // read burst returned
    output logic [2*DATA_W-1:0] rd_data, // beat 1 high, beat 0 low
    sram_link_if.ctl link // pins
);

    typedef struct packed {
        phase_t ph;
        logic lclk;
        logic k;
        logic k_n;
        logic c;
        logic c_n;
        logic read_n;
        logic write_n;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wd;
        logic [LANES-1:0] wm_n;
        logic p_rd;
        logic p_wr;
        logic [ADDR_W-1:0] p_ra;
        logic [ADDR_W-1:0] p_wa;
        logic [2*DATA_W-1:0] p_d;
        logic [2*LANES-1:0] p_m;
        logic ready;
        logic seen;
        logic valid;
        logic [2*DATA_W-1:0] rdat;
    } ctl_state_t;

    ctl_state_t st;
    ctl_state_t next_st;

    always_comb begin
        next_st = st;
        next_st.valid = 1'b0;
        case (st.ph)
            PH_ADRV: begin
                next_st.ph = PH_ASMP;
                next_st.lclk = 1'b1;
            end
            PH_ASMP: begin
                // slot B: K-bar high with write address and second beat
                next_st.ph = PH_BDRV;
                next_st.lclk = 1'b0;
                next_st.k = 1'b0;
                next_st.k_n = 1'b1; // R23
                next_st.read_n = 1'b1;
                next_st.write_n = 1'b1;
                next_st.addr = st.p_wa; // R04
                next_st.wd = st.p_d[DATA_W +: DATA_W]; // R06
                next_st.wm_n = st.p_m[LANES +: LANES]; // R08
                next_st.ready = 1'b1;
                // echo high marks the first beat of a returned burst
                if (link.read_data_oe && link.echo_clock_out) begin // R20
                    next_st.rdat[0 +: DATA_W] = link.read_data_out;
                    next_st.seen = 1'b1;
                end
            end
            PH_BDRV: begin
                next_st.ph = PH_BSMP;
                next_st.lclk = 1'b1;
                next_st.ready = 1'b0;
                next_st.p_rd = 1'b0;
                next_st.p_wr = 1'b0;
                if (cmd_valid) begin // R16
                    next_st.p_rd = rd_en;
                    next_st.p_wr = wr_en;
                    next_st.p_ra = rd_addr;
                    next_st.p_wa = wr_addr;
                    next_st.p_d = wr_data;
                    next_st.p_m = wr_mask_n;
                end
            end
            PH_BSMP: begin
                // slot A: K high with selects, read address and first beat
                next_st.ph = PH_ADRV;
                next_st.lclk = 1'b0;
                next_st.k = 1'b1;
                next_st.k_n = 1'b0; // R23
                next_st.read_n = ~st.p_rd;
                next_st.write_n = ~st.p_wr;
                next_st.addr = st.p_ra;
                next_st.wd = st.p_d[0 +: DATA_W]; // R05
                next_st.wm_n = st.p_m[0 +: LANES]; // R08
                if (st.seen && link.read_data_oe && !link.echo_clock_out) begin
                    next_st.rdat[DATA_W +: DATA_W] = link.read_data_out;
                    next_st.valid = 1'b1;
                end
                next_st.seen = 1'b0;
            end
            default: begin
                next_st.ph = PH_BDRV;
                next_st.lclk = 1'b0;
            end
        endcase
        // c pair follows K when used, otherwise both held high
        next_st.c = use_out_clk ? next_st.k : 1'b1; // R17 R18
        next_st.c_n = use_out_clk ? next_st.k_n : 1'b1;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
            st.ph <= PH_BDRV;
            st.c <= 1'b1;
            st.c_n <= 1'b1;
            st.read_n <= 1'b1;
            st.write_n <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign link.link_clk = st.lclk;
    assign link.k = st.k;
    assign link.k_n = st.k_n;
    assign link.c = st.c;
    assign link.c_n = st.c_n;
    assign link.read_n = st.read_n;
    assign link.write_n = st.write_n;
    assign link.shared_address_bus = st.addr;
    assign link.write_data_in = st.wd;
    assign link.byte_lane_mask_n = st.wm_n;
    assign cmd_ready = st.ready;
    assign rd_valid = st.valid;
    assign rd_data = st.rdat;

endmodule // sram_port_ctl

// file: hw/sram_link_pkg.sv
// constants, phase codes and lane merge shared by both ends of the burst-of-two DDR SRAM port
// assumes the link clock runs at twice the K rate; one link edge is one DDR beat
//
// Summary of operation
// R01 - read port captures address and select on K
// R02 - read data one cycle later, then half
// R03 - read select high gives read deselect cycle
// R04 - write select on K, write address on K-bar
// R05 - first write beat taken with write select
// R06 - second write beat taken on K-bar edge
// R07 - write select high stores nothing
// R08 - lane masks sampled with their data beats
// R09 - high mask keeps that lane unchanged
// R10 - each write address carries two beats
// R11 - any lane maskable on either beat
// R12 - one port never disturbs the other
// R13 - started bursts always run to completion
// R14 - deselected device still toggles echo clocks
// R15 - inputs captured only on clock edges
// R16 - alternation may start with read or write
// R17 - driven output clocks time data launch
// R18 - output clocks high means K timing
// R19 - echo clocks copy the launching clock pair
// R20 - echo clocks switch with read data
// R21 - word lsb zero then one per burst
// R22 - same-address read passes new write data
// R23 - controller drives K-bar half period offset
// R24 - read deselect floats both data beats
package sram_link_pkg;

    localparam int LANE_W = 9;
    localparam int LANES = 2;
    localparam int DATA_W = LANE_W * LANES;
    localparam int ADDR_W_DEF = 8;
    localparam logic BEAT0_LSB = 1'h0;
    localparam logic BEAT1_LSB = 1'h1;

    // controller phases, one link clock half-period each
    typedef enum logic [3:0] {
        PH_ADRV = 4'h1,
        PH_ASMP = 4'h2,
        PH_BDRV = 4'h4,
        PH_BSMP = 4'h8
    } phase_t;

    // overlay unmasked lanes of the new beat on the stored word
    function automatic logic [DATA_W-1:0] lane_merge(input logic [DATA_W-1:0] old_w,
                                                     input logic [DATA_W-1:0] new_w,
                                                     input logic [LANES-1:0] mask_n);
        logic [DATA_W-1:0] r;
        r = old_w;
        for (int i = 0; i < LANES; i++) begin
            if (!mask_n[i]) begin
                r[i*LANE_W +: LANE_W] = new_w[i*LANE_W +: LANE_W];
            end
        end
        return r;
    endfunction

endpackage

// file: hw/sram_link_if.sv
// pin bundle between the memory controller and the SRAM port
// assumes the controller makes link_clk; the pins it drives change away from its rising edge
`timescale 1ns/1ps
interface sram_link_if
    import sram_link_pkg::*;
    #(parameter int ADDR_W = ADDR_W_DEF) ();

    logic link_clk;
    logic k;
    logic k_n;
    logic c;
    logic c_n;
    logic read_n;
    logic write_n;
    logic [ADDR_W-1:0] shared_address_bus;
    logic [DATA_W-1:0] write_data_in;
    logic [LANES-1:0] byte_lane_mask_n;
    logic [DATA_W-1:0] read_data_out;
    logic read_data_oe;
    logic echo_clock_out;
    logic echo_clock_out_n;

    modport dev (
        input link_clk, k, k_n, c, c_n, read_n, write_n,
        input shared_address_bus, write_data_in, byte_lane_mask_n,
        output read_data_out, read_data_oe, echo_clock_out, echo_clock_out_n
    );

    modport ctl (
        output link_clk, k, k_n, c, c_n, read_n, write_n,
        output shared_address_bus, write_data_in, byte_lane_mask_n,
        input read_data_out, read_data_oe, echo_clock_out, echo_clock_out_n
    );

endinterface

// file: hw/sram_port_dev.sv
// SRAM end: burst-of-two DDR separate read and write ports over one address bus
// assumes every rising link_clk is one beat; k high marks K edges, k_n high K-bar edges
`timescale 1ns/1ps
module sram_port_dev
    import sram_link_pkg::*;
    (
    input wire logic rst_n, // link-domain async reset, active low
    sram_link_if.dev link // pins
);

    localparam int AW = $bits(link.shared_address_bus);
    localparam int WORDS = 2 ** (AW + 1);

    typedef struct packed {
        // read command captured on K
        logic rd_go;
        logic [AW-1:0] rd_addr;
        // write command and first beat captured on K
        logic wr_go;
        logic [DATA_W-1:0] wd0;
        logic [LANES-1:0] wm0_n;
        // read burst staged for launch in the next cycle
        logic st_valid;
        logic [DATA_W-1:0] st_q0;
        logic [DATA_W-1:0] st_q1;
        // second beat held from first launch
        logic h_valid;
        logic [DATA_W-1:0] h_q1;
        // output registers
        logic [DATA_W-1:0] dout;
        logic oe;
        logic echo;
        logic echo_n;
    } dev_state_t;

    dev_state_t st;
    dev_state_t next_st;

    // burst storage, two words per address
    logic [DATA_W-1:0] mem [WORDS];

    logic k_edge;
    logic kb_edge;
    logic c_mode;
    logic launch0;
    logic launch1;
    logic [AW:0] wr_a0;
    logic [AW:0] wr_a1;
    logic [AW:0] rd_a0;
    logic [AW:0] rd_a1;
    logic [DATA_W-1:0] new0;
    logic [DATA_W-1:0] new1;
    logic hit;

    always_comb begin
        k_edge = link.k;
        kb_edge = link.k_n & ~link.k;
        // both c inputs high means fall back to K timing
        c_mode = ~(link.c & link.c_n); // R18
        launch0 = c_mode ? link.c : link.k; // R17 R19
        launch1 = c_mode ? (link.c_n & ~link.c) : (link.k_n & ~link.k);
    end

    // word lsb is never an input; beat 0 is even, beat 1 odd
    always_comb begin
        wr_a0 = {link.shared_address_bus, BEAT0_LSB}; // R21
        wr_a1 = {link.shared_address_bus, BEAT1_LSB}; // R21
        rd_a0 = {st.rd_addr, BEAT0_LSB}; // R21
        rd_a1 = {st.rd_addr, BEAT1_LSB};
    end

    // masked lanes keep what is stored
    always_comb begin
        new0 = lane_merge(mem[wr_a0], st.wd0, st.wm0_n); // R09 R11
        new1 = lane_merge(mem[wr_a1], link.write_data_in, link.byte_lane_mask_n); // R09 R11
        hit = st.wr_go & st.rd_go & (st.rd_addr == link.shared_address_bus);
    end

    always_comb begin
        next_st = st;

        if (k_edge) begin
            // both ports take their commands on the same K edge, independently
            next_st.rd_go = ~link.read_n; // R01 R03 R12
            next_st.rd_addr = link.shared_address_bus; // R01 R15
            next_st.wr_go = ~link.write_n; // R04 R07 R12
            next_st.wd0 = link.write_data_in; // R05
            next_st.wm0_n = link.byte_lane_mask_n; // R08
        end

        if (kb_edge) begin
            // read lookup sits at the write address edge so a matching write
            // in the same cycle is seen; the stage is only refilled here,
            // after the previous burst has had its first beat launched
            next_st.st_valid = st.rd_go; // R02 R13
            if (hit) begin
                next_st.st_q0 = new0; // R22
                next_st.st_q1 = new1; // R22
            end else begin
                next_st.st_q0 = mem[rd_a0]; // R02
                next_st.st_q1 = mem[rd_a1];
            end
            // one command slot per K cycle; both go flags retire here
            next_st.rd_go = 1'b0;
            next_st.wr_go = 1'b0;
        end

        if (launch0) begin
            next_st.dout = st.st_q0; // R02
            next_st.oe = st.st_valid; // R24
            next_st.h_valid = st.st_valid;
            next_st.h_q1 = st.st_q1;
            next_st.echo = 1'b1; // R14 R19 R20
            next_st.echo_n = 1'b0; // R14 R19 R20
        end else if (launch1) begin
            // second beat from the hold, so a late c pair cannot race the refill
            next_st.dout = st.h_q1; // R02 R13
            next_st.oe = st.h_valid; // R24
            next_st.echo = 1'b0; // R14 R20
            next_st.echo_n = 1'b1; // R14 R20
        end

        // floated beats carry zeros so nothing stale leaks when oe is low
        if (!next_st.oe) begin
            next_st.dout = '0; // R24
        end
    end

    always_ff @(posedge link.link_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // memory has no reset; writes retire whole burst on the K-bar edge
    always_ff @(posedge link.link_clk) begin
        if (kb_edge && st.wr_go) begin // R07 R10
            mem[wr_a0] <= new0; // R05 R09
            mem[wr_a1] <= new1; // R06 R09
        end
    end

    assign link.read_data_out = st.dout;
    assign link.read_data_oe = st.oe;
    assign link.echo_clock_out = st.echo;
    assign link.echo_clock_out_n = st.echo_n;

endmodule // sram_port_dev

// file: testbench/sram_link_sva.sv
// checker on the pins between the controller end and the SRAM end
// assumes it sits beside the link interface; all sampling is on link_clk
`timescale 1ns/1ps
module sram_link_sva
    import sram_link_pkg::*;
    (
    input wire logic link_clk, // beat clock
    input wire logic rst_n, // reset, low
    input wire logic k, // K half
    input wire logic k_n, // K-bar half
    input wire logic c, // out clock
    input wire logic c_n, // out clock bar
    input wire logic read_n, // read select
    input wire logic [DATA_W-1:0] read_data_out, // read beat
    input wire logic read_data_oe, // data driven
    input wire logic echo_clock_out, // echo
    input wire logic echo_clock_out_n // echo bar
);
    default clocking cb @(posedge link_clk);
    endclocking
    default disable iff (!rst_n);

    // sampled values trail the launch by one beat, so a beat launched two beats on shows at ##3
    a_read_beats: assert property (
        k && !read_n |-> ##3 read_data_oe && echo_clock_out ##1 read_data_oe && !echo_clock_out)
        else $error("read beats out of place");
    a_read_deselect: assert property (
        k && read_n |-> ##3 !read_data_oe ##1 !read_data_oe)
        else $error("deselected read drove data");
    a_echo_toggles: assert property (
        k |-> ##1 echo_clock_out && !echo_clock_out_n ##1 !echo_clock_out && echo_clock_out_n)
        else $error("echo clocks stalled");
    a_float_zero: assert property (!read_data_oe |-> read_data_out == 18'h0_0000)
        else $error("data while floating");
    a_clock_alternate: assert property ((k |=> k_n && !k) and (k_n |=> k))
        else $error("K pair out of turn");
    a_out_clock_mode: assert property ((c && c_n) || (c == k && c_n == k_n))
        else $error("output clocks neither tied nor following");
    a_burst_whole: assert property (
        $rose(read_data_oe) |-> echo_clock_out ##1 read_data_oe)
        else $error("read burst cut short");
    a_oe_from_read: assert property (
        $rose(read_data_oe) |-> $past(k, 3) && !$past(read_n, 3))
        else $error("data without a read");
endmodule // sram_link_sva

// file: testbench/tb_separate_io_ddr_burst2_sram_port.sv
// bench: controller end and SRAM end joined by the link, driven from the user side
// assumes one rst_n for both ends; the controller divides mclk into link_clk
`timescale 1ns/1ps
module tb_separate_io_ddr_burst2_sram_port
    import sram_link_pkg::*;
    ();
    localparam int W = 2 * DATA_W;
    localparam logic [W-1:0] DAT_A = 36'h1_2345_6789;
    localparam logic [W-1:0] DAT_B = 36'hF_EDCB_A987;
    localparam logic [W-1:0] OLD_W = 36'hA_AAAA_AAAA;
    localparam logic [W-1:0] NEW_W = 36'h5_5555_5555;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic use_out_clk = 1'b1;
    logic cmd_valid = 1'b0;
    logic rd_en = 1'b0, wr_en = 1'b0;
    logic [7:0] rd_addr = 8'h00, wr_addr = 8'h00;
    logic [W-1:0] wr_data = 36'h0_0000_0000;
    logic [3:0] wr_mask_n = 4'hf;
    logic cmd_ready, rd_valid;
    logic [W-1:0] rd_data;
    logic [W-1:0] got[$];
    int bad_count = 0;
    int checks_done = 0;

    sram_link_if #(.ADDR_W(8)) link ();
    sram_port_ctl #(.ADDR_W(8)) i_sram_port_ctl (
        .mclk(mclk), .rst_n(rst_n), .use_out_clk(use_out_clk), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .rd_en(rd_en), .rd_addr(rd_addr), .wr_en(wr_en),
        .wr_addr(wr_addr), .wr_data(wr_data), .wr_mask_n(wr_mask_n), .rd_valid(rd_valid),
        .rd_data(rd_data), .link(link)
    );
    sram_port_dev i_sram_port_dev (.rst_n(rst_n), .link(link));
    sram_link_sva i_sram_link_sva (
        .link_clk(link.link_clk), .rst_n(rst_n), .k(link.k), .k_n(link.k_n), .c(link.c),
        .c_n(link.c_n), .read_n(link.read_n), .read_data_out(link.read_data_out),
        .read_data_oe(link.read_data_oe), .echo_clock_out(link.echo_clock_out),
        .echo_clock_out_n(link.echo_clock_out_n)
    );

    initial begin
        forever #4 mclk = ~mclk;
    end

    // results can overlap in flight, so they are queued and judged in order
    always @(negedge mclk) begin
        if (rd_valid === 1'b1) begin
            got.push_back(rd_data);
        end
    end

    task automatic check(input logic [W-1:0] seen, input logic [W-1:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %0t read %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic give_up();
        bad_count++;
        $display("ERROR %0t wait ran out", $time);
        test_done();
    endtask

    // valid stays up across calls; a second call at the taking edge just swaps the payload
    task automatic cmd(input logic r, input logic [7:0] ra, input logic w,
                       input logic [7:0] wa, input logic [W-1:0] wd, input logic [3:0] wm);
        int n;
        n = 0;
        cmd_valid <= 1'b1;
        rd_en <= r;
        rd_addr <= ra;
        wr_en <= w;
        wr_addr <= wa;
        wr_data <= wd;
        wr_mask_n <= wm;
        do begin
            @(negedge mclk);
            n++;
            if (n > 8) give_up();
        end while (cmd_ready !== 1'b1);
        @(posedge mclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [W-1:0] d, input logic [3:0] m);
        cmd(1'b0, 8'h00, 1'b1, a, d, m);
    endtask

    task automatic rd(input logic [7:0] a);
        cmd(1'b1, a, 1'b0, 8'h00, 36'h0_0000_0000, 4'hf);
    endtask

    task automatic expect_rd(input logic [W-1:0] exp);
        int n;
        n = 0;
        cmd_valid <= 1'b0;
        while (got.size() == 0) begin
            @(negedge mclk);
            n++;
            if (n > 40) give_up();
        end
        check(got.pop_front(), exp);
        @(posedge mclk);
    endtask

    function automatic logic [W-1:0] keep(input logic [W-1:0] o, input logic [W-1:0] nw,
                                          input logic [3:0] m);
        logic [W-1:0] r;
        r = nw;
        for (int i = 0; i < 4; i++) begin
            if (m[i]) begin
                r[i*LANE_W +: LANE_W] = o[i*LANE_W +: LANE_W];
            end
        end
        return r;
    endfunction

    task automatic t_burst_order();
        wr(8'h05, DAT_A, 4'h0);
        wr(8'h06, DAT_B, 4'h0);
        rd(8'h05);
        rd(8'h06);
        expect_rd(DAT_A);
        expect_rd(DAT_B);
    endtask

    task automatic t_masks();
        for (int m = 0; m < 16; m++) begin
            wr(8'h40 + 8'(m), OLD_W, 4'h0);
            wr(8'h40 + 8'(m), NEW_W, 4'(m));
            rd(8'h40 + 8'(m));
            expect_rd(keep(OLD_W, NEW_W, 4'(m)));
        end
    endtask

    task automatic t_mixed();
        rd(8'h05);
        cmd(1'b1, 8'h05, 1'b1, 8'h05, NEW_W, 4'h6);
        cmd(1'b1, 8'h06, 1'b1, 8'h07, OLD_W, 4'h0);
        cmd(1'b1, 8'h06, 1'b0, 8'h06, NEW_W, 4'h0);
        rd(8'h07);
        rd(8'h06);
        expect_rd(DAT_A);
        expect_rd(keep(DAT_A, NEW_W, 4'h6));
        expect_rd(DAT_B);
        expect_rd(DAT_B);
        expect_rd(OLD_W);
        expect_rd(DAT_B);
    endtask

    initial begin
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (8) @(posedge mclk);
        t_burst_order();
        t_masks();
        use_out_clk <= 1'b0;
        repeat (8) @(posedge mclk);
        t_mixed();
        test_done();
    end
endmodule // tb_separate_io_ddr_burst2_sram_port
